// File: verilog/csdp_pkg.sv
// Shared constants, field layouts and divider decode for the clock select and divide path
`default_nettype none
package csdp_pkg;
   // Channel count and register word indices (byte address is four times the index)
   localparam int unsigned CSDP_NCH = 5;
   localparam logic [2:0] CSDP_IDX_PRI = 3'h0;
   localparam logic [2:0] CSDP_IDX_SEC = 3'h1;
   localparam logic [2:0] CSDP_IDX_REFLO = 3'h2;
   localparam logic [2:0] CSDP_IDX_REFHI = 3'h3;
   localparam logic [2:0] CSDP_IDX_CH_LAST = 3'h4;
   localparam logic [2:0] CSDP_IDX_SEL = 3'h5;
   localparam logic [2:0] CSDP_IDX_STAT = 3'h6;

   // Writable masks and reset values
   localparam logic [31:0] CSDP_CH_WMASK = 32'h0fdffff3;
   localparam logic [31:0] CSDP_SEL_WMASK = 32'h0000003d;
   localparam logic [31:0] CSDP_CH_RST = 32'h00000000;
   localparam logic [31:0] CSDP_SEL_RST = 32'h00000024;

   // Input select word fields
   localparam int unsigned CSDP_SEL_LSB = 2;
   localparam int unsigned CSDP_AUX_SRC_BIT = 0;

   // Input select patterns {auto_select_enable, aux, secondary, primary}
   localparam logic [3:0] CSDP_MODE_MAN_PRI = 4'h9;
   localparam logic [3:0] CSDP_MODE_MAN_SEC = 4'ha;
   localparam logic [3:0] CSDP_MODE_MAN_AUX = 4'hc;
   localparam logic [3:0] CSDP_MODE_AUTO2 = 4'hb;
   localparam logic [3:0] CSDP_MODE_AUTO3 = 4'hf;
   localparam logic [3:0] CSDP_MODE_PIN = 4'h3;

   // Pin positions in the synchroniser vector
   localparam int unsigned CSDP_PIN_PRI = 0;
   localparam int unsigned CSDP_PIN_SEC = 1;
   localparam int unsigned CSDP_PIN_AUX = 2;
   localparam int unsigned CSDP_PIN_SYN = 3;
   localparam int unsigned CSDP_PIN_RSEL = 4;

   // Pre-divider, buffer type, pin mode and divider class codes
   localparam logic [1:0] CSDP_PD_DIV2 = 2'h1;
   localparam logic [1:0] CSDP_PD_THRU = 2'h2;
   localparam logic [1:0] CSDP_BUF_SE = 2'h0;
   localparam logic [1:0] CSDP_BUF_OFF = 2'h2;
   localparam logic [1:0] CSDP_PM_HIZ = 2'h1;
   localparam logic [1:0] CSDP_PM_LOW = 2'h3;
   localparam logic [1:0] CSDP_DT_CASC = 2'h0;
   localparam logic [1:0] CSDP_DT_BYP = 2'h1;
   localparam logic [1:0] CSDP_DT_PRE = 2'h2;
   // Supported cascade codes, bit index {k, prescaler}
   localparam logic [31:0] CSDP_CASC_OK = 32'hcfe8ceee;

   // Timing: loss of signal window and restore count
   localparam int unsigned CSDP_CLK_MHZ = 250;
   localparam int unsigned CSDP_LOS_NS = 256;
   localparam logic [7:0] CSDP_LOS_CYC = 8'(CSDP_LOS_NS * CSDP_CLK_MHZ / 1000);
   localparam logic [2:0] CSDP_RESTORE_CYC = 3'h4;

   // Bus responses
   localparam logic [1:0] CSDP_RESP_OKAY = 2'h0;
   localparam logic [1:0] CSDP_RESP_SLVERR = 2'h2;

   // Channel configuration word layout
   typedef struct packed {
      logic [3:0] rsvd_hi;
      logic buffer_type_sel_y;
      logic buffer_type_sel_x;
      logic neg_pin_mode_y;
      logic neg_pin_mode_x;
      logic pos_pin_mode_y;
      logic pos_pin_mode_x;
      logic rsvd_21;
      logic channel_divider_enable;
      logic [6:0] channel_divider_select;
      logic [6:0] coarse_phase;
      logic channel_source_sel_y;
      logic channel_source_sel_x;
      logic [1:0] rsvd_lo;
      logic [1:0] input_ctl;
   } csdp_chan_cfg_t;

   // Decoded divider setting
   typedef struct packed {
      logic valid;
      logic presc_only;
      logic [6:0] ratio;
   } csdp_div_t;

   typedef enum logic [1:0] {CSDP_RUN, CSDP_FAIL, CSDP_BACK} csdp_sm_t;

   // Turns the divider select field into a ratio; unsupported codes stay invalid
   function automatic csdp_div_t csdp_decode(input logic [6:0] sel, input logic en);
      csdp_div_t d;
      logic [1:0] p;
      logic [2:0] k;
      d = '0;
      p = sel[1:0];
      k = sel[4:2];
      if (en) begin
         if (sel[6:5] == CSDP_DT_BYP && sel[4:0] == 5'h00) begin
            d.valid = 1'b1;
            d.ratio = 7'h01;
         end else if (sel[6:5] == CSDP_DT_PRE && k == 3'h0) begin
            d.valid = 1'b1;
            d.presc_only = 1'b1;
            d.ratio = 7'(p) + 7'h02;
         end else if (sel[6:5] == CSDP_DT_CASC && CSDP_CASC_OK[{k, p}]) begin
            d.valid = 1'b1;
            d.ratio = ((7'(p) + 7'h02) * (7'(k) + 7'h01)) << 1;
         end
      end
      return d;
   endfunction
endpackage
`default_nettype wire

// File: verilog/csdp_out_div.sv
// Sampled-clock divider with coarse phase delay and restart
`default_nettype none
module csdp_out_div import csdp_pkg::*; #(
   parameter int unsigned RW = 7
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_in,
   input wire logic run,
   input wire logic [RW-1:0] ratio,
   input wire logic [RW-1:0] phase,
   input wire logic resync,
   output logic div_out
);
   logic in_d_r;
   logic run_d_r;
   logic [RW-1:0] cnt_r;
   logic [RW-1:0] wait_r;

   // Edge of the sampled input and derived limits
   wire rise = clk_in & ~in_d_r;
   wire one = (ratio == RW'(1));
   wire [RW-1:0] last = ratio - RW'(1);
   wire [RW-1:0] half = ratio >> 1;
   wire [RW-1:0] ph_lim = (ratio == '0) ? '0 : ((phase >= ratio) ? last : phase);
   wire restart = ~run | ~run_d_r | resync;

   // Delay the start by ph_lim input edges, then count modulo ratio
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         in_d_r <= 1'b0;
         run_d_r <= 1'b0;
         cnt_r <= '0;
         wait_r <= '0;
         div_out <= 1'b0;
      end else begin
         in_d_r <= clk_in;
         run_d_r <= run;
         if (restart) begin
            cnt_r <= '0;
            wait_r <= ph_lim;
            div_out <= 1'b0;
         end else begin
            if (rise && wait_r != '0) begin
               wait_r <= wait_r - RW'(1);
            end else if (rise) begin
               cnt_r <= (cnt_r >= last) ? '0 : cnt_r + RW'(1); // Wraps at once if ratio shrank
            end
            div_out <= one ? clk_in : (wait_r == '0 && cnt_r < half);
         end
      end
   end
endmodule
`default_nettype wire

// File: verilog/csdp_top.sv
// Clock select and divide path: failover input mux, pre and reference dividers, five channels
`default_nettype none
module csdp_top import csdp_pkg::*; #(
   parameter int unsigned ADDR_W = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic primary_reference,
   input wire logic secondary_reference,
   input wire logic aux_reference,
   input wire logic synthesizer_clock,
   input wire logic ref_select,
   output logic failover_mux_clock,
   output logic aux_out,
   output logic [CSDP_NCH-1:0] chan_pos_out,
   output logic [CSDP_NCH-1:0] chan_pos_oe,
   output logic [CSDP_NCH-1:0] chan_neg_out,
   output logic [CSDP_NCH-1:0] chan_neg_oe
);
   // Maps a byte address onto {hit, word index}
   function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
      logic [2:0] idx;
      idx = a[4:2];
      return {((a >> 5) == '0) && (idx <= CSDP_IDX_STAT), idx};
   endfunction

   // Pre-divider select: disconnect, half rate or straight through
   function automatic logic prediv(input logic [1:0] code, input logic thru, input logic half);
      return (code == CSDP_PD_THRU) ? thru : ((code == CSDP_PD_DIV2) ? half : 1'b0);
   endfunction

   logic [31:0] cfg_r [0:5];
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic resync_r;
   logic [4:0] pin_s1_r;
   logic [4:0] pin_s2_r;
   logic [4:0] pin_d_r;
   logic pri_half_r;
   logic sec_half_r;
   logic [2:0] stg_d_r;
   logic [7:0] los_cnt_r [0:2];
   logic [2:0] rec_cnt_r [0:2];
   logic [2:0] good_r;
   csdp_sm_t sm_r;
   csdp_sm_t sm_nxt;
   logic [1:0] cur_r;
   logic [1:0] cur_nxt;
   logic [1:0] tgt_r;
   logic [1:0] tgt_nxt;
   logic mux_r;
   logic smart_clk;
   logic [CSDP_NCH-1:0] dclk;
   logic [CSDP_NCH-1:0] pos_nxt;
   logic [CSDP_NCH-1:0] neg_nxt;
   logic [CSDP_NCH-1:0] poe_nxt;
   logic [CSDP_NCH-1:0] noe_nxt;
   logic [CSDP_NCH-1:0] chan_src;
   csdp_div_t chan_dec [CSDP_NCH];

   // Write path decode
   wire aw_fire = s_axi_awvalid & awready_r;
   wire w_fire = s_axi_wvalid & wready_r;
   wire do_wr = ~awready_r & ~wready_r & ~bvalid_r;
   wire [3:0] wr_dec = reg_index(awaddr_r);
   wire wr_ok = wr_dec[3] && (wr_dec[2:0] != CSDP_IDX_STAT);
   wire [31:0] wr_mask = (wr_dec[2:0] == CSDP_IDX_SEL) ? CSDP_SEL_WMASK : CSDP_CH_WMASK;
   wire [31:0] byte_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire [31:0] wr_bits = byte_mask & wr_mask;

   // Read path decode
   wire ar_fire = s_axi_arvalid & arready_r;
   wire [3:0] rd_dec = reg_index(s_axi_araddr);
   wire rd_stat = rd_dec[2:0] == CSDP_IDX_STAT;
   wire [31:0] status = {25'h0, sm_r == CSDP_BACK, sm_r == CSDP_FAIL, ~good_r, cur_r};
   wire [31:0] rd_word = !rd_dec[3] ? 32'h0 : (rd_stat ? status : cfg_r[rd_dec[2:0]]);

   // Access to any channel word restarts the channel and aux dividers, not the reference divider
   wire wr_chan = do_wr & wr_dec[3] & (wr_dec[2:0] <= CSDP_IDX_CH_LAST);
   wire rd_chan = ar_fire & rd_dec[3] & (rd_dec[2:0] <= CSDP_IDX_CH_LAST);

   // Register file with byte strobes
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 6; i++) begin
         if (!nrst) begin
            cfg_r[i] <= (i == 5) ? CSDP_SEL_RST : CSDP_CH_RST;
         end else if (do_wr && wr_ok && wr_dec[2:0] == 3'(i)) begin
            cfg_r[i] <= (cfg_r[i] & ~wr_bits) | (wdata_r & wr_bits);
         end
      end
   end

   // Write address and data capture, response after both
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= CSDP_RESP_OKAY;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         if (aw_fire) begin
            awaddr_r <= s_axi_awaddr;
            awready_r <= 1'b0;
         end
         if (w_fire) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            wready_r <= 1'b0;
         end
         if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? CSDP_RESP_OKAY : CSDP_RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // Read channel and divider restart pulse
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= CSDP_RESP_OKAY;
         resync_r <= 1'b0;
      end else begin
         resync_r <= wr_chan | rd_chan;
         if (ar_fire) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_dec[3] ? CSDP_RESP_OKAY : CSDP_RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Pin synchronisers; the delayed copy only serves edge detection
   wire [4:0] pins = {ref_select, synthesizer_clock, aux_reference, secondary_reference,
                      primary_reference};
   wire [4:0] pin_rise = pin_s2_r & ~pin_d_r;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_d_r <= '0;
         pri_half_r <= 1'b0;
         sec_half_r <= 1'b0;
      end else begin
         pin_s1_r <= pins;
         pin_s2_r <= pin_s1_r;
         pin_d_r <= pin_s2_r;
         pri_half_r <= pri_half_r ^ pin_rise[CSDP_PIN_PRI];
         sec_half_r <= sec_half_r ^ pin_rise[CSDP_PIN_SEC];
      end
   end

   // First multiplexer stage inputs after the pre-dividers
   wire pri_s = pin_s2_r[CSDP_PIN_PRI];
   wire sec_s = pin_s2_r[CSDP_PIN_SEC];
   wire pri_pd = prediv(cfg_r[CSDP_IDX_PRI][1:0], pri_s, pri_half_r);
   wire sec_pd = prediv(cfg_r[CSDP_IDX_SEC][1:0], sec_s, sec_half_r);
   wire [2:0] stg = {pin_s2_r[CSDP_PIN_AUX], sec_pd, pri_pd};
   wire [2:0] stg_rise = stg & ~stg_d_r;
   wire [2:0] stg_fall = ~stg & stg_d_r;

   // Loss monitor: silent window declares loss, four full cycles restore
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         stg_d_r <= '0;
         good_r <= '0;
         for (int j = 0; j < 3; j++) begin
            los_cnt_r[j] <= '0;
            rec_cnt_r[j] <= '0;
         end
      end else begin
         stg_d_r <= stg;
         for (int j = 0; j < 3; j++) begin
            if (stg_rise[j]) begin
               los_cnt_r[j] <= '0;
               if (!good_r[j] && rec_cnt_r[j] == CSDP_RESTORE_CYC) begin
                  good_r[j] <= 1'b1;
               end else if (!good_r[j]) begin
                  rec_cnt_r[j] <= rec_cnt_r[j] + 3'h1;
               end
            end else if (los_cnt_r[j] == CSDP_LOS_CYC - 8'h01) begin
               good_r[j] <= 1'b0;
               rec_cnt_r[j] <= '0;
            end else begin
               los_cnt_r[j] <= los_cnt_r[j] + 8'h01;
            end
         end
      end
   end

   // Select pattern decode
   wire [3:0] sel_code = cfg_r[CSDP_IDX_SEL][CSDP_SEL_LSB +: 4];
   wire aux_src3 = cfg_r[CSDP_IDX_SEL][CSDP_AUX_SRC_BIT];
   wire auto3 = sel_code == CSDP_MODE_AUTO3;
   wire auto_m = (sel_code == CSDP_MODE_AUTO2) | auto3;
   wire pin_m = sel_code == CSDP_MODE_PIN;
   wire man_sec = sel_code == CSDP_MODE_MAN_SEC;
   wire man_aux = sel_code == CSDP_MODE_MAN_AUX;
   wire fix_ok = (sel_code == CSDP_MODE_MAN_PRI) | man_sec | man_aux | pin_m;
   wire pin_sec = pin_s2_r[CSDP_PIN_RSEL];
   wire [1:0] fix_idx = man_aux ? 2'h2 : {1'b0, man_sec | (pin_m & pin_sec)};
   wire [3:0] cand = {1'b0, good_r & {auto3, 2'b11}};
   wire any = |cand;
   wire [1:0] desired = cand[0] ? 2'h0 : (cand[1] ? 2'h1 : 2'h2);
   wire [3:0] rise4 = {1'b0, stg_rise};
   wire [3:0] fall4 = {1'b0, stg_fall};
   wire [3:0] stg4 = {1'b0, stg};

   // Failover sequencing in the automatic modes
   always_comb begin
      sm_nxt = sm_r;
      cur_nxt = cur_r;
      tgt_nxt = tgt_r;
      if (!auto_m) begin
         sm_nxt = CSDP_RUN;
         cur_nxt = fix_idx;
      end else begin
         unique case (sm_r)
            CSDP_RUN: begin
               if (any && !cand[cur_r]) begin
                  sm_nxt = CSDP_FAIL;
                  tgt_nxt = desired;
               end else if (any && desired < cur_r) begin
                  sm_nxt = CSDP_BACK;
                  tgt_nxt = desired;
               end
            end
            CSDP_FAIL: begin
               if (!cand[tgt_r]) begin
                  sm_nxt = CSDP_RUN;
               end else if (rise4[tgt_r]) begin
                  sm_nxt = CSDP_RUN;
                  cur_nxt = tgt_r;
               end
            end
            CSDP_BACK: begin
               if (!cand[tgt_r]) begin
                  sm_nxt = CSDP_RUN;
               end else if (fall4[tgt_r]) begin
                  sm_nxt = CSDP_RUN;
                  cur_nxt = tgt_r;
               end
            end
         endcase
      end
   end

   // Multiplexer output: low while failing over, high while switching back
   wire mux_nxt = (!auto_m && !fix_ok) ? 1'b0 :
                  (sm_r == CSDP_FAIL) ? 1'b0 :
                  (sm_r == CSDP_BACK) ? 1'b1 : stg4[cur_r];

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sm_r <= CSDP_RUN;
         cur_r <= 2'h0;
         tgt_r <= 2'h0;
         mux_r <= 1'b0;
      end else begin
         sm_r <= sm_nxt;
         cur_r <= cur_nxt;
         tgt_r <= tgt_nxt;
         mux_r <= mux_nxt;
      end
   end

   // Reference divider after the first stage
   wire [6:0] ref_ratio = 7'({cfg_r[CSDP_IDX_REFHI][0], cfg_r[CSDP_IDX_REFLO][1:0]}) + 7'h01;

   csdp_out_div u_ref_div (
      .core_clk(core_clk),
      .nrst(nrst),
      .clk_in(mux_r),
      .run(1'b1),
      .ratio(ref_ratio),
      .phase(7'h00),
      .resync(1'b0),
      .div_out(smart_clk)
   );

   assign failover_mux_clock = smart_clk;
   // Distribution bus: primary, secondary, failover, synthesizer
   wire [3:0] dist_bus = {pin_s2_r[CSDP_PIN_SYN], smart_clk, sec_s, pri_s};

   // Output channels
   for (genvar i = 0; i < CSDP_NCH; i++) begin : g_ch
      csdp_chan_cfg_t c;
      logic [1:0] bt;
      logic [1:0] pm;
      logic [1:0] nm;
      logic se;
      assign c = cfg_r[i];
      assign chan_dec[i] = csdp_decode(c.channel_divider_select,
                                       c.channel_divider_enable);
      assign chan_src[i] = dist_bus[{c.channel_source_sel_x, c.channel_source_sel_y}];
      assign bt = {c.buffer_type_sel_x, c.buffer_type_sel_y};
      assign pm = {c.pos_pin_mode_x, c.pos_pin_mode_y};
      assign nm = {c.neg_pin_mode_x, c.neg_pin_mode_y};
      assign se = bt == CSDP_BUF_SE;

      csdp_out_div u_div (
         .core_clk(core_clk),
         .nrst(nrst),
         .clk_in(chan_src[i]),
         .run(chan_dec[i].valid),
         .ratio(chan_dec[i].ratio),
         .phase(c.coarse_phase),
         .resync(resync_r),
         .div_out(dclk[i])
      );

      // Buffer type and single-ended pin modes
      assign pos_nxt[i] = se ? (pm != CSDP_PM_LOW) & dclk[i] : dclk[i];
      assign neg_nxt[i] = se ? (nm != CSDP_PM_LOW) & dclk[i] : ~dclk[i];
      assign poe_nxt[i] = se ? (pm != CSDP_PM_HIZ) : (bt != CSDP_BUF_OFF);
      assign noe_nxt[i] = se ? (nm != CSDP_PM_HIZ) : (bt != CSDP_BUF_OFF);
   end

   // Auxiliary divider follows channel 2 or 3
   wire [2:0] aux_ch = aux_src3 ? 3'h3 : 3'h2;
   csdp_div_t aux_dec;
   assign aux_dec = chan_dec[aux_ch];
   wire aux_run = aux_dec.valid && aux_dec.ratio != 7'h01;
   wire [6:0] aux_ratio = aux_dec.presc_only ? aux_dec.ratio << 1 : aux_dec.ratio;

   csdp_out_div u_aux_div (
      .core_clk(core_clk),
      .nrst(nrst),
      .clk_in(chan_src[aux_ch]),
      .run(aux_run),
      .ratio(aux_ratio),
      .phase(7'h00),
      .resync(resync_r),
      .div_out(aux_out)
   );

   // Registered pad drivers
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         chan_pos_out <= '0;
         chan_neg_out <= '0;
         chan_pos_oe <= '0;
         chan_neg_oe <= '0;
      end else begin
         chan_pos_out <= pos_nxt;
         chan_neg_out <= neg_nxt;
         chan_pos_oe <= poe_nxt;
         chan_neg_oe <= noe_nxt;
      end
   end
endmodule
`default_nettype wire

// File: tb/csdp_ref_src.sv
// Reference clock source that parks low while disabled
`default_nettype none
module csdp_ref_src #(
   parameter int HALF = 20
) (
   input wire logic en,
   output logic clk
);
   timeunit 1ns;
   timeprecision 100ps;
   // Offset start keeps edges clear of the core clock
   initial begin
      clk = 1'b0;
      #0.3;
      forever begin
         #(HALF);
         clk = en ? ~clk : 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: tb/csdp_monitor.sv
// Concurrent checks on the register bus and reset state
`default_nettype none
module csdp_monitor import csdp_pkg::*; (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [CSDP_NCH-1:0] chan_pos_out
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Answers stand until taken, readies stay low meanwhile
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid lost");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
   w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write not refused");
   r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not refused");
   // Each read, and each write with address and data taken together, gets its answer promptly
   b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read answer");
   r_cause_a: assert property ($rose(s_axi_rvalid) |->
      $past(s_axi_arvalid) && $past(s_axi_arready)) else $error("unasked read answer");
   // Reset leaves the bus idle and the disabled pins low
   rst_idle_a: assert property (disable iff (1'b0) !nrst |=>
      s_axi_awready && !s_axi_bvalid && !s_axi_rvalid && chan_pos_out == '0)
      else $error("reset state wrong");
   // Main traffic seen
   cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == CSDP_RESP_SLVERR);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property ($rose(chan_pos_out[0]));
endmodule
bind csdp_top csdp_monitor mon (.*);
`default_nettype wire

// File: tb/csdp_top_tb.sv
// Self-checking bench for the clock select and divide path
`default_nettype none
module csdp_top_tb import csdp_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = '0, nrst = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0, ref_select = '0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [2:0] src_en = 3'h7;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic primary_reference, secondary_reference, aux_reference, synthesizer_clock;
   logic failover_mux_clock, aux_out;
   logic [4:0] chan_pos_out, chan_pos_oe, chan_neg_out, chan_neg_oe;
   int n_errors = 0, cmp_count = 0, cyc = 0, f, c, x, g;
   // Far-side clock sources
   csdp_ref_src #(.HALF(20)) pri_src (.en(src_en[0]), .clk(primary_reference));
   csdp_ref_src #(.HALF(24)) sec_src (.en(src_en[1]), .clk(secondary_reference));
   csdp_ref_src #(.HALF(28)) aux_src (.en(src_en[2]), .clk(aux_reference));
   csdp_ref_src #(.HALF(12)) syn_src (.en(1'b1), .clk(synthesizer_clock));
   csdp_top dut (.*);
   initial forever #2 core_clk = ~core_clk;
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Cuts a hung run short
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   function automatic logic near(int a, int b);
      return a - b <= 1 && b - a <= 1;
   endfunction
   // Bus write: offer both, release each when taken, then take the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(negedge core_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= '0;
         if (tw) s_axi_wvalid <= '0;
      end while (s_axi_awvalid && !ta || s_axi_wvalid && !tw);
      do @(negedge core_clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      @(posedge core_clk);
      s_axi_bready <= '0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(negedge core_clk); while (!s_axi_arready);
      @(posedge core_clk);
      s_axi_arvalid <= '0;
      do @(negedge core_clk); while (!s_axi_rvalid);
      {d, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge core_clk);
      s_axi_rready <= '0;
      @(posedge core_clk);
   endtask
   // Counts rising edges of the mux, channel 0 and aux outputs
   task automatic cnt(input int n);
      logic pf, pc, px;
      f = 0;
      c = 0;
      x = 0;
      g = 0;
      {pf, pc, px} = {failover_mux_clock, chan_pos_out[0], aux_out};
      repeat (n) begin
         @(negedge core_clk);
         f += int'(failover_mux_clock && !pf);
         c += int'(chan_pos_out[0] && !pc);
         x += int'(aux_out && !px);
         g += int'(chan_pos_out[0] != chan_pos_out[2]);
         {pf, pc, px} = {failover_mux_clock, chan_pos_out[0], aux_out};
      end
      @(posedge core_clk);
   endtask
   // Reset value, masked read-back, refused places
   task automatic t_bus();
      rd(8'h14);
      chk(d, CSDP_SEL_RST);
      rd(8'h1c);
      chk(32'(r), 32'(CSDP_RESP_SLVERR));
      wr(8'h18, 32'h0);
      chk(32'(r), 32'(CSDP_RESP_SLVERR));
      wr(8'h14, '1);
      rd(8'h14);
      chk(d, CSDP_SEL_WMASK);
   endtask
   // Row: pattern, enables, select pin, pre-div, ref-div, edges in 400 cycles
   task automatic t_mode();
      logic [23:0] m [13] = '{24'h9e8028, 24'hae8021, 24'hce801c, 24'hbe8028,
         24'hbc8021, 24'hbe8028, 24'hf8801c, 24'h3e8028, 24'h3f8021, 24'h5e8000,
         24'h9e4014,
         24'h9eb00a, 24'h9e0000};
      wr(8'h04, 32'h2);
      foreach (m[i]) begin
         wr(8'h00, 32'h140010 | 32'(m[i][15:14]));
         wr(8'h08, 32'(m[i][13:12]));
         wr(8'h14, 32'(m[i][23:20]) << 2);
         {src_en, ref_select} <= m[i][19:16];
         repeat (200) @(posedge core_clk);
         cnt(400);
         chk(32'(near(f, m[i][7:0])), 32'h1);
         chk(32'(near(c, m[i][7:0])), 32'h1);
      end
   endtask
   // Row: enable and select, channel edges and aux edges in 1200 cycles
   task automatic t_div();
      logic [23:0] v [7] = '{24'ha07800, 24'hc03c1e, 24'hc3180c, 24'h811414,
         24'h820f0f, 24'he00000, 24'h400000};
      wr(8'h14, 32'h24);
      foreach (v[i]) begin
         wr(8'h00, 32'(v[i][23:16]) << 13 | 32'h2);
         wr(8'h08, 32'(v[i][23:16]) << 13);
         repeat (50) @(posedge core_clk);
         cnt(1200);
         chk(32'(near(c, v[i][15:8])), 32'h1);
         chk(32'(near(x, v[i][7:0])), 32'h1);
         chk(32'(g), 32'h0);
      end
   endtask
   // Pin modes on channel 4
   task automatic t_buf();
      wr(8'h10, 32'h3800000);
      repeat (4) @(posedge core_clk);
      chk(32'({chan_pos_oe[4], chan_neg_oe[4], chan_neg_out[4]}), 32'h2);
      wr(8'h10, 32'h8000000);
      repeat (4) @(posedge core_clk);
      chk(32'({chan_pos_oe[4], chan_neg_oe[4], chan_neg_out[4]}), 32'h7);
      wr(8'h10, 32'h4000000);
      repeat (4) @(posedge core_clk);
      chk(32'({chan_pos_oe[4], chan_neg_oe[4]}), 32'h0);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_bus();
      t_mode();
      t_div();
      t_buf();
      final_report();
   end
endmodule
`default_nettype wire
